// *** srx_consts.vh ***
`ifndef SRX_CONSTS_VH
`define SRX_CONSTS_VH

// register byte offsets
`define SRX_OFF_STATUS     4'h0
`define SRX_OFF_MODE       4'h4
`define SRX_OFF_DATA       4'h8
`define SRX_OFF_DIVISOR    4'hc

// receive_status_control fields
`define SRX_BIT_PORT_ON    7
`define SRX_BIT_NINE       6
`define SRX_BIT_SINGLE     5
`define SRX_BIT_CONT       4
`define SRX_BIT_ADDR_DET   3
`define SRX_BIT_FRAMING_ERROR_FLAG       2
`define SRX_BIT_OVERRUN_ERROR_FLAG       1
`define SRX_BIT_RECEIVED_NINTH_BIT       0

// mode register fields
`define SRX_BIT_MASTER     7
`define SRX_BIT_TX_EN      5
`define SRX_BIT_SYNC       4

// data register fields
`define SRX_BIT_DATA_VALID 9

// reset values
`define SRX_RST_STATUS     8'h00
`define SRX_RST_MODE       8'h00
`define SRX_RST_DIVISOR    16'h0010

// async oversampling: last tick of a bit, mid-start check point
`define SRX_OS_LAST        4'hf
`define SRX_OS_MID         4'h7

// axi responses
`define SRX_RESP_OKAY      2'b00
`define SRX_RESP_SLVERR    2'b10

`endif

// *** srx_engine.v ***
`timescale 1ns/1ps
`default_nettype none

`include "srx_consts.vh"

module srx_engine (
    input  wire       clk_in,
    input  wire       sys_rst_in,
    input  wire       run_in,
    input  wire       sync_in,
    input  wire       master_in,
    input  wire       nine_in,
    input  wire       tick_in,
    input  wire       data_in,
    input  wire       sclk_in,
    output reg        sclk_out,
    output reg        done_out,
    output reg  [8:0] char_out,
    output reg        framing_error_flag_out
);

    reg        busy;
    reg  [3:0] os;
    reg  [3:0] bitn;
    reg  [8:0] shreg;
    reg        sclk_d;
    wire [3:0] last_bit = nine_in ? 4'h9 : 4'h8;
    wire [8:0] next_sh  = {data_in, shreg[8:1]};
    wire [8:0] aligned  = nine_in ? next_sh : {1'b0, next_sh[8:1]};
    // slave samples on the rising edge of the already synchronised clock pin
    // master needs divisor 3 or more, else synchroniser lag samples the previous bit
    wire       shift_sync = master_in ? (tick_in & ~sclk_out) : (sclk_in & ~sclk_d);

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy     <= 1'b0;
            os       <= 4'h0;
            bitn     <= 4'h0;
            shreg    <= 9'h000;
            sclk_d   <= 1'b0;
            sclk_out <= 1'b0;
            done_out <= 1'b0;
            char_out <= 9'h000;
            framing_error_flag_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            sclk_d   <= sclk_in;
            if (!run_in) begin
                busy     <= 1'b0;
                os       <= 4'h0;
                bitn     <= 4'h0;
                sclk_out <= 1'b0;
            end else if (sync_in) begin
                if (master_in && tick_in) begin
                    sclk_out <= ~sclk_out;
                end
                if (shift_sync) begin
                    shreg <= next_sh;
                    if (bitn + 4'h1 == last_bit) begin
                        bitn     <= 4'h0;
                        done_out <= 1'b1;
                        char_out <= aligned;
                        framing_error_flag_out <= 1'b0;
                    end else begin
                        bitn <= bitn + 4'h1;
                    end
                end
            end else if (!busy) begin
                if (tick_in && !data_in) begin
                    busy <= 1'b1;
                    os   <= 4'h0;
                    bitn <= 4'h0;
                end
            end else if (tick_in) begin
                os <= os + 4'h1;
                if (bitn == 4'h0) begin
                    if (os == `SRX_OS_MID) begin
                        // a glitch shorter than half a bit is not a start
                        if (data_in) begin
                            busy <= 1'b0;
                        end else begin
                            os   <= 4'h0;
                            bitn <= 4'h1;
                        end
                    end
                end else if (os == `SRX_OS_LAST) begin
                    if (bitn == last_bit + 4'h1) begin
                        busy     <= 1'b0;
                        done_out <= 1'b1;
                        char_out <= nine_in ? shreg : {1'b0, shreg[8:1]};
                        framing_error_flag_out <= ~data_in;
                    end else begin
                        shreg <= next_sh;
                        bitn  <= bitn + 4'h1;
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** srx_top.v ***
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "srx_consts.vh"

// Functional notes
// - sync master: setting single-receive starts one character; clear leaves it off.
// - sync master: hardware clears single-receive when that character completes, unless continuous-receive is on.
// - single-receive is ignored in async mode and in sync slave mode.
// - async: continuous-receive switches the receiver on and off.
// - sync: an active receive request overrides the transmit enable.
// - sync: continuous-receive runs until cleared and overrides single-receive.
// - mode-select bit picks sync or async and steers enable decoding.
module srx_top #(
    parameter [15:0] DIVISOR_RESET = `SRX_RST_DIVISOR
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire [3:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [3:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire        receive_data_pin_in,
    output reg         receive_data_pin_out,
    output reg         receive_data_pin_oe_n_out,
    input  wire        transmit_clock_pin_in,
    output reg         transmit_clock_pin_out,
    output reg         transmit_clock_pin_oe_n_out,
    output reg         transmit_grant_out
);

    // status / control
    reg        serial_port_on;
    reg        nine_bit_receive_select;
    reg        single_receive_request;
    reg        continuous_receive_enable;
    reg        address_detect_enable;
    reg        framing_error_flag;
    reg        overrun_error_flag;
    reg        sync_mode;
    reg        master_mode;
    reg        transmit_enable_bit;
    reg [15:0] divisor;
    reg [8:0]  held_char;
    reg        held_valid;

    // bus state
    reg        aw_hold;
    reg        w_hold;
    reg [3:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    // pin synchronisers; stage one feeds only stage two
    reg [1:0]  rx_sync;
    reg [1:0]  ck_sync;

    reg [15:0] baud_cnt;
    reg        tick;

    wire       eng_sclk;
    wire       eng_done;
    wire [8:0] eng_char;
    wire       eng_framing_error_flag;

    wire wr_en   = aw_hold & w_hold & ~s_axi_bvalid_out;
    wire wr_stat = wr_en & (aw_addr == `SRX_OFF_STATUS) & w_strb[0];
    wire wr_mode = wr_en & (aw_addr == `SRX_OFF_MODE) & w_strb[0];
    wire ar_take = s_axi_arready_out & s_axi_arvalid_in;
    wire pop     = ar_take & (s_axi_araddr_in == `SRX_OFF_DATA);

    wire master_single = sync_mode & master_mode & single_receive_request;
    wire rx_run        = serial_port_on & (continuous_receive_enable | master_single);
    wire tx_grant      = serial_port_on & transmit_enable_bit & ~(sync_mode & rx_run);
    // the single character ends the request only when continuous receive is off
    wire single_done   = eng_done & master_single & ~continuous_receive_enable;
    // address detect: a 9-bit async character without the ninth bit is dropped
    wire keep_char     = ~(address_detect_enable & ~sync_mode & nine_bit_receive_select & ~eng_char[8]);
    wire load_char     = eng_done & keep_char;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_sync <= 2'b11;
            ck_sync <= 2'b00;
        end else begin
            rx_sync <= {rx_sync[0], receive_data_pin_in};
            ck_sync <= {ck_sync[0], transmit_clock_pin_in};
        end
    end

    // one tick per divisor+1 cycles: 16 per bit async, two per bit in sync master
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            baud_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (!rx_run || baud_cnt == divisor) begin
            baud_cnt <= 16'h0000;
            tick     <= rx_run;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    srx_engine u_engine (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .run_in     (rx_run),
        .sync_in    (sync_mode),
        .master_in  (master_mode),
        .nine_in    (nine_bit_receive_select),
        .tick_in    (tick),
        .data_in    (rx_sync[1]),
        .sclk_in    (ck_sync[1]),
        .sclk_out   (eng_sclk),
        .done_out   (eng_done),
        .char_out   (eng_char),
        .framing_error_flag_out   (eng_framing_error_flag)
    );

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            serial_port_on            <= 1'b0;
            nine_bit_receive_select   <= 1'b0;
            single_receive_request    <= 1'b0;
            continuous_receive_enable <= 1'b0;
            address_detect_enable     <= 1'b0;
            framing_error_flag        <= 1'b0;
            overrun_error_flag        <= 1'b0;
            sync_mode                 <= 1'b0;
            master_mode               <= 1'b0;
            transmit_enable_bit       <= 1'b0;
            divisor                   <= DIVISOR_RESET;
            held_char                 <= 9'h000;
            held_valid                <= 1'b0;
        end else begin
            if (wr_stat) begin
                serial_port_on            <= w_data[`SRX_BIT_PORT_ON];
                nine_bit_receive_select   <= w_data[`SRX_BIT_NINE];
                continuous_receive_enable <= w_data[`SRX_BIT_CONT];
                address_detect_enable     <= w_data[`SRX_BIT_ADDR_DET];
            end
            if (wr_mode) begin
                master_mode         <= w_data[`SRX_BIT_MASTER];
                transmit_enable_bit <= w_data[`SRX_BIT_TX_EN];
                sync_mode           <= w_data[`SRX_BIT_SYNC];
            end
            if (wr_en && aw_addr == `SRX_OFF_DIVISOR) begin
                if (w_strb[0]) divisor[7:0] <= w_data[7:0];
                if (w_strb[1]) divisor[15:8] <= w_data[15:8];
            end
            // software set beats the hardware clear in the same cycle
            if (wr_stat) begin
                single_receive_request <= w_data[`SRX_BIT_SINGLE];
            end else if (single_done) begin
                single_receive_request <= 1'b0;
            end
            // overrun set wins over the clear by dropping continuous receive
            if (load_char && held_valid && !pop) begin
                overrun_error_flag <= 1'b1;
            end else if ((wr_stat && !w_data[`SRX_BIT_CONT]) || !serial_port_on) begin
                overrun_error_flag <= 1'b0;
            end
            if (load_char && (!held_valid || pop)) begin
                held_char          <= eng_char;
                framing_error_flag <= eng_framing_error_flag;
                held_valid         <= 1'b1;
            end else if (pop) begin
                held_valid <= 1'b0;
            end
        end
    end

    // pins: oe_n low while driven; receiving in sync leaves the data pin free
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            receive_data_pin_out        <= 1'b1;
            receive_data_pin_oe_n_out   <= 1'b1;
            transmit_clock_pin_out      <= 1'b1;
            transmit_clock_pin_oe_n_out <= 1'b1;
            transmit_grant_out          <= 1'b0;
        end else begin
            transmit_grant_out        <= tx_grant;
            receive_data_pin_out      <= 1'b1;
            receive_data_pin_oe_n_out <= ~(serial_port_on & sync_mode & tx_grant);
            if (!serial_port_on) begin
                transmit_clock_pin_out      <= 1'b1;
                transmit_clock_pin_oe_n_out <= 1'b1;
            end else if (!sync_mode) begin
                transmit_clock_pin_out      <= 1'b1;
                transmit_clock_pin_oe_n_out <= 1'b0;
            end else begin
                transmit_clock_pin_out      <= eng_sclk;
                transmit_clock_pin_oe_n_out <= ~(master_mode & (rx_run | tx_grant));
            end
        end
    end

    // axi4-lite write: address and data taken in either order
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `SRX_RESP_OKAY;
            aw_hold           <= 1'b0;
            w_hold            <= 1'b0;
            aw_addr           <= 4'h0;
            w_data            <= 32'h00000000;
            w_strb            <= 4'h0;
        end else begin
            if (s_axi_awready_out && s_axi_awvalid_in) begin
                s_axi_awready_out <= 1'b0;
                aw_hold           <= 1'b1;
                aw_addr           <= s_axi_awaddr_in;
            end else if (!aw_hold && !s_axi_bvalid_out) begin
                s_axi_awready_out <= 1'b1;
            end
            if (s_axi_wready_out && s_axi_wvalid_in) begin
                s_axi_wready_out <= 1'b0;
                w_hold           <= 1'b1;
                w_data           <= s_axi_wdata_in;
                w_strb           <= s_axi_wstrb_in;
            end else if (!w_hold && !s_axi_bvalid_out) begin
                s_axi_wready_out <= 1'b1;
            end
            if (wr_en) begin
                aw_hold          <= 1'b0;
                w_hold           <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (aw_addr[1:0] == 2'b00) ? `SRX_RESP_OKAY : `SRX_RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // axi4-lite read; reading the data word releases the held character
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= `SRX_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= `SRX_RESP_OKAY;
            case (s_axi_araddr_in)
                `SRX_OFF_STATUS: begin
                    s_axi_rdata_out <= {24'h000000, serial_port_on, nine_bit_receive_select,
                                        single_receive_request, continuous_receive_enable,
                                        address_detect_enable, framing_error_flag,
                                        overrun_error_flag, held_char[8]};
                end
                `SRX_OFF_MODE: begin
                    s_axi_rdata_out <= {24'h000000, master_mode, 1'b0, transmit_enable_bit,
                                        sync_mode, 4'h0};
                end
                `SRX_OFF_DATA: begin
                    s_axi_rdata_out <= {22'h000000, held_valid, held_char};
                end
                `SRX_OFF_DIVISOR: begin
                    s_axi_rdata_out <= {16'h0000, divisor};
                end
                default: begin
                    s_axi_rdata_out <= 32'h00000000;
                    s_axi_rresp_out <= `SRX_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end else if (!s_axi_rvalid_out) begin
            s_axi_arready_out <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** srx_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module srx_props (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [3:0]  s_axi_awaddr_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0]  s_axi_wstrb_in,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [3:0]  s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic        receive_data_pin_oe_n_out,
    input wire logic        transmit_clock_pin_oe_n_out,
    input wire logic        transmit_grant_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // shadow lags the real bits by one edge, hence the [*2] antecedents
    logic [3:0] wr_addr;
    logic [7:0] wr_byte;
    logic       wr_lane, sh_on, sh_cont, sh_tx, sh_sync;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {wr_addr, wr_byte, wr_lane, sh_on, sh_cont, sh_tx, sh_sync} <= '0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) wr_addr <= s_axi_awaddr_in;
            if (s_axi_wvalid_in && s_axi_wready_out) {wr_lane, wr_byte} <= {s_axi_wstrb_in[0], s_axi_wdata_in[7:0]};
            if ($rose(s_axi_bvalid_out) && s_axi_bresp_out == 2'h0 && wr_lane) begin
                if (wr_addr == 4'h0) {sh_on, sh_cont} <= {wr_byte[7], wr_byte[4]};
                if (wr_addr == 4'h4) {sh_tx, sh_sync} <= {wr_byte[5], wr_byte[4]};
            end
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out)
        else $error("write answer not on time");
    AST_B_ONCE: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("write answer held after handshake");
    AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid_out)
        else $error("read answer not on time");
    AST_RD_SLVERR: assert property (s_rd_taken ##0 s_axi_araddr_in[1:0] != 2'h0 |=> s_axi_rresp_out == 2'h2)
        else $error("unaligned read not refused");
    AST_OFF_PINS: assert property ((!sh_on) [*2] |->
        receive_data_pin_oe_n_out && transmit_clock_pin_oe_n_out && !transmit_grant_out)
        else $error("pins held while port off");
    AST_ASYNC_CLK_PIN: assert property ((sh_on && !sh_sync) [*2] |-> !transmit_clock_pin_oe_n_out)
        else $error("clock pin not taken in async");
    AST_ASYNC_DATA_FREE: assert property ((!sh_sync) [*2] |-> receive_data_pin_oe_n_out)
        else $error("data pin driven in async");
    AST_ASYNC_GRANT: assert property ((sh_on && sh_tx && !sh_sync) [*2] |-> transmit_grant_out)
        else $error("transmit not granted in async");
    AST_SYNC_RX_PRIO: assert property ((sh_on && sh_sync && sh_cont) [*2] |-> !transmit_grant_out)
        else $error("transmit granted while receiving");
endmodule

bind srx_top srx_props u_props (.*);
`default_nettype wire

// *** srx_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module srx_far_end (
    input  wire logic clk_in,
    input  wire logic clk_pin_in,
    output var  logic data_out,
    output var  logic clk_out
);
    logic [8:0] ans_char;
    int         ans_bits;
    int         ans_idx;
    initial begin
        data_out = 1'b1;
        clk_out = 1'b0;  // clock stands low outside frames
        ans_bits = 0;
    end
    task automatic arm(input logic [8:0] ch, input int n);
        ans_char = ch;
        ans_idx = 0;
        ans_bits = n;
        data_out <= ch[0];
    endtask
    // bits change on falling clock so the master samples a stable level
    always @(negedge clk_pin_in) begin
        if (ans_bits != 0) begin
            ans_idx = ans_idx + 1;
            if (ans_idx == ans_bits) begin
                ans_bits = 0;
                data_out <= ~data_out;  // released line shows no stale bit
            end else begin
                data_out <= ans_char[ans_idx];
            end
        end
    end
    task automatic send_async(input logic [8:0] ch, input int n, input int bit_clks);
        data_out <= 1'b0;
        repeat (bit_clks) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            data_out <= ch[i];
            repeat (bit_clks) @(posedge clk_in);
        end
        data_out <= 1'b1;
        repeat (bit_clks) @(posedge clk_in);
    endtask
    task automatic send_slave(input logic [8:0] ch, input int n);
        for (int i = 0; i < n; i++) begin
            data_out <= ch[i];
            repeat (8) @(posedge clk_in);
            clk_out <= 1'b1;
            repeat (8) @(posedge clk_in);
            clk_out <= 1'b0;
        end
        repeat (8) @(posedge clk_in);
        data_out <= ~ch[n-1];
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int BIT_CLKS = 32;  // 16 ticks per bit at divisor 1
    typedef struct packed {
        logic        wr;
        logic [3:0]  a;
        logic [31:0] d;
        logic [31:0] exp;
        logic [1:0]  resp;
    } srx_row_t;
    logic        clk_in, sys_rst_in, far_data, far_clk;
    logic [3:0]  s_axi_awaddr_in, s_axi_wstrb_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
    logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic        receive_data_pin_out, receive_data_pin_oe_n_out, transmit_clock_pin_out;
    logic        transmit_clock_pin_oe_n_out, transmit_grant_out;
    int          err_total, total_checks;
    wire         receive_data_pin_in = receive_data_pin_oe_n_out ? far_data : receive_data_pin_out;
    wire         transmit_clock_pin_in = transmit_clock_pin_oe_n_out ? far_clk : transmit_clock_pin_out;
    srx_row_t    rows [9] = '{
        '{1'b0, 4'h0, 32'h0, 32'h0, 2'h0}, '{1'b0, 4'h4, 32'h0, 32'h0, 2'h0},
        '{1'b0, 4'hc, 32'h0, 32'h10, 2'h0}, '{1'b1, 4'h4, 32'hb0, 32'hb0, 2'h0},
        '{1'b1, 4'h0, 32'h4f, 32'h48, 2'h0}, '{1'b1, 4'h0, 32'h0, 32'h0, 2'h0},
        '{1'b1, 4'hc, 32'h1, 32'h1, 2'h0}, '{1'b1, 4'h8, 32'h1ff, 32'h0, 2'h0},
        '{1'b1, 4'h2, 32'h5, 32'h0, 2'h2}};
    srx_top DUT (.*);
    srx_far_end FAR (.clk_in, .clk_pin_in(transmit_clock_pin_in), .data_out(far_data), .clk_out(far_clk));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] wr);
        logic aw_done = 1'b0, w_done = 1'b0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= wd;
        {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h3;
        while (!(aw_done && w_done)) begin
            @(posedge clk_in);
            if (!aw_done && s_axi_awready_out === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid_in <= 1'b0;
            end
            if (!w_done && s_axi_wready_out === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid_in <= 1'b0;
            end
        end
        do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
        wr = s_axi_bresp_out;
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] rd, output logic [1:0] rr);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        {rd, rr} = {s_axi_rdata_out, s_axi_rresp_out};
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] wd);
        axi_write(a, wd, r);
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        axi_read(a, rd, r);
        check(what, rd, exp);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        finish_test;
    end
    initial begin
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in, s_axi_bready_in, s_axi_rready_in} = 5'h3;
        s_axi_wstrb_in = 4'hf;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].a, rows[i].d, r);
                check("write resp", {30'h0, r}, {30'h0, rows[i].resp});
            end
            axi_read(rows[i].a, d, r);
            check("read data", d, rows[i].exp);
            check("read resp", {30'h0, r}, {30'h0, rows[i].resp});
        end
        wr(4'h4, 32'h20);
        wr(4'h0, 32'h90);
        repeat (3) @(posedge clk_in);
        check("async pins", {27'h0, receive_data_pin_out, transmit_clock_pin_out,
              receive_data_pin_oe_n_out, transmit_clock_pin_oe_n_out, transmit_grant_out}, 32'h1d);
        FAR.send_async(9'h05a, 8, BIT_CLKS);
        repeat (4) @(posedge clk_in);
        rd_chk("char 8 bit", 4'h8, 32'h25a);
        wr(4'h0, 32'hd0);
        FAR.send_async(9'h1a5, 9, BIT_CLKS);
        repeat (4) @(posedge clk_in);
        rd_chk("status ninth", 4'h0, 32'hd1);
        rd_chk("char 9 bit", 4'h8, 32'h3a5);
        wr(4'h0, 32'ha0);
        FAR.send_async(9'h0c3, 8, BIT_CLKS);
        repeat (4) @(posedge clk_in);
        rd_chk("async single", 4'h8, 32'h1a5);
        wr(4'hc, 32'h3);
        wr(4'h4, 32'hb0);
        wr(4'h0, 32'h80);
        repeat (3) @(posedge clk_in);
        check("grant idle", {31'h0, transmit_grant_out}, 32'h1);
        FAR.arm(9'h03c, 8);
        wr(4'h0, 32'ha0);
        repeat (3) @(posedge clk_in);
        check("grant rx", {31'h0, transmit_grant_out}, 32'h0);
        d = 32'h20;
        for (int n = 0; n < 60 && d[5] === 1'b1; n++) axi_read(4'h0, d, r);
        check("single cleared", d & 32'hf0, 32'h80);
        rd_chk("char sync", 4'h8, 32'h23c);
        wr(4'h0, 32'hb0);
        repeat (100) @(posedge clk_in);
        check("grant cont", {31'h0, transmit_grant_out}, 32'h0);
        axi_read(4'h0, d, r);
        check("cont over single", d & 32'hf0, 32'hb0);
        wr(4'h0, 32'h80);
        axi_read(4'h8, d, r);  // drop the leftover character
        wr(4'h4, 32'h10);
        wr(4'h0, 32'ha0);
        FAR.send_slave(9'h05a, 8);
        repeat (8) @(posedge clk_in);
        rd_chk("slave single", 4'h8, 32'h0ff);
        wr(4'h0, 32'h90);
        FAR.send_slave(9'h0c3, 8);
        repeat (8) @(posedge clk_in);
        rd_chk("slave char", 4'h8, 32'h2c3);
        wr(4'h0, 32'h00);
        repeat (3) @(posedge clk_in);
        check("pins off", {29'h0, receive_data_pin_oe_n_out,
              transmit_clock_pin_oe_n_out, transmit_grant_out}, 32'h6);
        finish_test;
    end
endmodule
`default_nettype wire
